// ### shared/lpf_regs.svh
// constants of the low power freeze control block
`ifndef LPF_REGS_SVH
`define LPF_REGS_SVH

// ****************************************
// register map
// ****************************************
`define LPF_ADDR_W 8
`define LPF_DATA_W 32
`define LPF_CTRL_OFS 8'h00
`define LPF_DIV_OFS 8'h04
`define LPF_STAT_OFS 8'h08
`define LPF_CTRL_RST 32'h00000000
`define LPF_DIV_RST 32'h00010101

// ****************************************
// structure of the block
// ****************************************
`define LPF_N_BANKS 4
`define LPF_BANK_W 8
`define LPF_DIV_W 5
`define LPF_N_OUT 3
`define LPF_PH_W 2
`define LPF_CNT_W 8
`define LPF_BANK_STEP 3
`define LPF_GLOB_AT 2

// ****************************************
// timing
// ****************************************
`define LPF_CLK_PERIOD_NS 40
`define LPF_ACQ_TIME_NS 300000
`define LPF_ACQ_CYC \
  ((`LPF_ACQ_TIME_NS + `LPF_CLK_PERIOD_NS - 1) / `LPF_CLK_PERIOD_NS)
`define LPF_ACQ_W 16

`endif

// ### shared/lpf_pkg.sv
// types of the low power freeze control block
`include "lpf_regs.svh"
package lpf_pkg;

  // ****************************************
  // sequencer states, one-hot
  // ****************************************
  typedef enum logic [3:0] {
    LPF_RUN = 4'h1,
    LPF_FROZEN = 4'h2,
    LPF_EXIT = 4'h4,
    LPF_LOCK = 4'h8
  } lpf_state_e;

  // ****************************************
  // register contents
  // ****************************************
  typedef struct packed {
    logic [`LPF_N_BANKS-1:0] hold_en;
    logic [`LPF_PH_W-1:0] phase_sel;
    logic qual_en;
  } lpf_cfg_s;

  typedef struct packed {
    logic [`LPF_DIV_W-1:0] div_c;
    logic [`LPF_DIV_W-1:0] div_b;
    logic [`LPF_DIV_W-1:0] div_a;
  } lpf_div_s;

  typedef struct packed {
    logic [`LPF_N_BANKS-1:0] bank_en;
    logic glob_en;
    logic ready;
    logic lock;
    logic pll_on;
    logic [3:0] state;
  } lpf_stat_s;

endpackage

// ### logic/lpf_sync.sv
// two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/10ps
module lpf_sync #(
  parameter int WIDTH = 1
) (
  // clock, reset and enable
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // data
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= '0;
      o_sync <= '0;
    end else if (i_clk_en) begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule // lpf_sync

// ### logic/lpf_clk_div.sv
// output divider that follows the oscillator phase selection
`timescale 1ns/10ps
`include "lpf_regs.svh"
module lpf_clk_div (
  // clock, reset and enable
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // control
  input wire logic i_run,
  input wire logic i_osc,
  input wire logic [`LPF_DIV_W-1:0] i_div,
  // divided clock
  output logic o_clk
);

  logic osc_d;
  logic [`LPF_DIV_W-1:0] cnt;
  logic [`LPF_DIV_W-1:0] next_cnt;
  logic [`LPF_DIV_W-1:0] eff;
  logic [`LPF_DIV_W-1:0] half;
  logic osc_rise;

  // ratio zero acts as one; high for the first half
  assign eff = (i_div == '0) ? `LPF_DIV_W'(1) : i_div;
  // rounded-up half without a carry out of the field width
  assign half = (eff >> 1) + `LPF_DIV_W'(eff[0]);
  assign osc_rise = i_osc & ~osc_d;
  assign next_cnt = (cnt >= eff - `LPF_DIV_W'(1)) ? '0 :
                    cnt + `LPF_DIV_W'(1);

  // count phased oscillator edges, stop with the pll
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_d <= 1'b0;
      cnt <= '0;
      o_clk <= 1'b0;
    end else if (i_clk_en) begin
      osc_d <= i_osc & i_run;
      if (!i_run) begin
        cnt <= '0;
        o_clk <= 1'b0;
      end else begin
        if (osc_rise) begin
          cnt <= next_cnt;
        end
        o_clk <= (eff == `LPF_DIV_W'(1)) ? i_osc : (cnt < half);
      end
    end
  end

endmodule // lpf_clk_div

// ### logic/lpf_freeze_ctrl.sv
// freeze sequencer: pll stop, pad control, staged exit
`timescale 1ns/10ps
`include "lpf_regs.svh"
module lpf_freeze_ctrl #(
  parameter int N_BANKS = `LPF_N_BANKS,
  parameter int BANK_W = `LPF_BANK_W,
  parameter logic [`LPF_ACQ_W-1:0] ACQ_CYC = `LPF_ACQ_W'(`LPF_ACQ_CYC)
) (
  // clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // register port
  input wire logic [`LPF_ADDR_W-1:0] i_addr,
  input wire logic [`LPF_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [`LPF_DATA_W-1:0] o_rdata,
  // freeze requests
  input wire logic i_freeze_request_pin,
  input wire logic i_core_freeze_request,
  // pll
  input wire logic i_pll_lock,
  output logic o_pll_powerdown,
  output logic o_global_clock_out_a,
  output logic o_global_clock_out_b,
  output logic o_global_clock_out_c,
  output logic o_glob_en,
  output logic o_clocks_ready,
  // pads and core
  input wire logic [N_BANKS*BANK_W-1:0] i_pad_in,
  input wire logic [N_BANKS*BANK_W-1:0] i_core_out,
  output logic [N_BANKS*BANK_W-1:0] o_pad_out,
  output logic [N_BANKS*BANK_W-1:0] o_pad_oe_n,
  output logic [N_BANKS*BANK_W-1:0] o_core_in,
  // jtag
  input wire logic i_jtag_req,
  output logic o_jtag_accept,
  output logic o_jtag_refuse
);

  localparam int SW = N_BANKS * BANK_W + 3;
  localparam logic [`LPF_CNT_W-1:0] EXIT_END =
    `LPF_CNT_W'(`LPF_BANK_STEP * N_BANKS);

  // ****************************************
  // synchronised pins
  // ****************************************
  logic [SW-1:0] sync_out;
  logic [N_BANKS*BANK_W-1:0] pad_s;
  logic pin_s;
  logic lock_s;
  logic jtag_s;

  lpf_sync #(
    .WIDTH(SW)
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .i_async({i_pad_in, i_freeze_request_pin, i_pll_lock, i_jtag_req}),
    .o_sync(sync_out)
  );

  assign {pad_s, pin_s, lock_s, jtag_s} = sync_out;

  // ****************************************
  // registers
  // ****************************************
  lpf_pkg::lpf_cfg_s cfg;
  lpf_pkg::lpf_div_s div;
  lpf_pkg::lpf_stat_s stat;
  lpf_pkg::lpf_state_e state;
  lpf_pkg::lpf_state_e next_state;
  logic [`LPF_CNT_W-1:0] exit_cnt;
  logic [`LPF_ACQ_W-1:0] acq_cnt;
  logic [N_BANKS-1:0] bank_en;
  logic glob_en;
  logic pll_on;
  logic ready;
  logic jtag_d;
  logic [`LPF_PH_W-1:0] osc_ph;

  // address decode
  function automatic logic hit(input logic [`LPF_ADDR_W-1:0] a,
                               input logic [`LPF_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  logic wr_ctrl;
  logic wr_div;
  logic [`LPF_DATA_W-1:0] rd_mux;

  assign wr_ctrl = i_wr & hit(i_addr, `LPF_CTRL_OFS);
  assign wr_div = i_wr & hit(i_addr, `LPF_DIV_OFS);

  // status view of the sequencer
  assign stat.bank_en = bank_en;
  assign stat.glob_en = glob_en;
  assign stat.ready = ready;
  assign stat.lock = lock_s;
  assign stat.pll_on = pll_on;
  assign stat.state = state;

  // read selection, unmapped reads give zero
  assign rd_mux =
    hit(i_addr, `LPF_CTRL_OFS) ? `LPF_DATA_W'(cfg) :
    hit(i_addr, `LPF_DIV_OFS) ? `LPF_DATA_W'(div) :
    hit(i_addr, `LPF_STAT_OFS) ? `LPF_DATA_W'(stat) : '0;

  // register writes and one-cycle read data
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg <= lpf_pkg::lpf_cfg_s'(`LPF_CTRL_RST);
      div <= lpf_pkg::lpf_div_s'(`LPF_DIV_RST);
      o_rdata <= '0;
    end else if (i_clk_en) begin
      if (wr_ctrl) begin
        cfg <= lpf_pkg::lpf_cfg_s'(i_wdata[$bits(cfg)-1:0]);
      end
      if (wr_div) begin
        div <= lpf_pkg::lpf_div_s'(i_wdata[$bits(div)-1:0]);
      end
      o_rdata <= i_rd ? rd_mux : '0;
    end
  end

  // ****************************************
  // freeze sequencer
  // ****************************************
  logic freeze_cond;
  logic exit_done;
  logic acq_done;

  // pin alone, or pin and core request when qualified
  assign freeze_cond = pin_s &
    (~cfg.qual_en | i_core_freeze_request);
  assign exit_done = (exit_cnt >= EXIT_END);
  assign acq_done = (acq_cnt >= ACQ_CYC);

  // next state
  always_comb begin
    next_state = state;
    case (state)
      lpf_pkg::LPF_RUN: begin
        if (freeze_cond) begin
          next_state = lpf_pkg::LPF_FROZEN;
        end
      end
      lpf_pkg::LPF_FROZEN: begin
        if (!pin_s) begin
          next_state = lpf_pkg::LPF_EXIT;
        end
      end
      lpf_pkg::LPF_EXIT: begin
        if (freeze_cond) begin
          next_state = lpf_pkg::LPF_FROZEN;
        end else if (exit_done) begin
          next_state = lpf_pkg::LPF_LOCK;
        end
      end
      lpf_pkg::LPF_LOCK: begin
        if (freeze_cond) begin
          next_state = lpf_pkg::LPF_FROZEN;
        end else if (acq_done && lock_s) begin
          next_state = lpf_pkg::LPF_RUN;
        end
      end
      default: begin
        next_state = lpf_pkg::LPF_FROZEN;
      end
    endcase
  end

  // state, exit stagger and acquisition counters
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= lpf_pkg::LPF_RUN;
      exit_cnt <= '0;
      acq_cnt <= '0;
    end else if (i_clk_en) begin
      state <= next_state;
      if (state == lpf_pkg::LPF_EXIT && !exit_done) begin
        exit_cnt <= exit_cnt + `LPF_CNT_W'(1);
      end else if (state != lpf_pkg::LPF_EXIT) begin
        exit_cnt <= '0;
      end
      if (!pll_on) begin
        acq_cnt <= '0;
      end else if (!acq_done) begin
        acq_cnt <= acq_cnt + `LPF_ACQ_W'(1);
      end
    end
  end

  // pll enable, global release and ready flag
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pll_on <= 1'b1;
      glob_en <= 1'b1;
      ready <= 1'b0;
      o_pll_powerdown <= 1'b0;
      o_glob_en <= 1'b1;
      o_clocks_ready <= 1'b0;
    end else if (i_clk_en) begin
      pll_on <= (next_state != lpf_pkg::LPF_FROZEN);
      o_pll_powerdown <= (next_state == lpf_pkg::LPF_FROZEN);
      if (next_state == lpf_pkg::LPF_FROZEN) begin
        glob_en <= 1'b0;
        o_glob_en <= 1'b0;
      end else if (state == lpf_pkg::LPF_EXIT &&
                   exit_cnt == `LPF_CNT_W'(`LPF_GLOB_AT)) begin
        glob_en <= 1'b1;
        o_glob_en <= 1'b1;
      end
      ready <= (next_state == lpf_pkg::LPF_RUN) && lock_s;
      o_clocks_ready <= (next_state == lpf_pkg::LPF_RUN) && lock_s;
    end
  end

  // ****************************************
  // per bank pad and core input control
  // ****************************************
  genvar b;
  generate
    for (b = 0; b < N_BANKS; b++) begin : g_bank
      logic bank_on;
      logic [BANK_W-1:0] core_o;
      logic [BANK_W-1:0] pad_i;

      assign core_o = i_core_out[b*BANK_W +: BANK_W];
      assign pad_i = pad_s[b*BANK_W +: BANK_W];
      // bank b wakes at its own step of the exit count
      assign bank_on = (state == lpf_pkg::LPF_EXIT) &&
        (exit_cnt == `LPF_CNT_W'(`LPF_BANK_STEP * (b + 1)));

      always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          bank_en[b] <= 1'b1;
        end else if (i_clk_en) begin
          if (next_state == lpf_pkg::LPF_FROZEN) begin
            bank_en[b] <= 1'b0;
          end else if (bank_on) begin
            bank_en[b] <= 1'b1;
          end
        end
      end

      // pad driver: live, held, or floating
      always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_pad_out[b*BANK_W +: BANK_W] <= '0;
          o_pad_oe_n[b*BANK_W +: BANK_W] <= '1;
          o_core_in[b*BANK_W +: BANK_W] <= '1;
        end else if (i_clk_en) begin
          if (bank_en[b]) begin
            // release follows the output signal through a flop, glitches between edges do not pass
            o_pad_out[b*BANK_W +: BANK_W] <= core_o;
            o_pad_oe_n[b*BANK_W +: BANK_W] <= '0;
            o_core_in[b*BANK_W +: BANK_W] <= pad_i;
          end else begin
            if (!cfg.hold_en[b]) begin
              o_pad_oe_n[b*BANK_W +: BANK_W] <= '1;
              o_pad_out[b*BANK_W +: BANK_W] <= '0;
            end
            o_core_in[b*BANK_W +: BANK_W] <= '1;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // jtag gate
  // ****************************************
  logic jtag_rise;
  logic jtag_block;

  assign jtag_rise = jtag_s & ~jtag_d;
  assign jtag_block = (state == lpf_pkg::LPF_FROZEN) ||
                      (state == lpf_pkg::LPF_EXIT);

  // requests pass only in the run and lock states, refused while frozen or in exit
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      jtag_d <= 1'b0;
      o_jtag_accept <= 1'b0;
      o_jtag_refuse <= 1'b0;
    end else if (i_clk_en) begin
      jtag_d <= jtag_s;
      o_jtag_accept <= jtag_rise & ~jtag_block;
      o_jtag_refuse <= jtag_rise & jtag_block;
    end
  end

  // ****************************************
  // oscillator phases and output dividers
  // ****************************************
  logic [`LPF_N_OUT-1:0] osc_sel;
  logic [`LPF_N_OUT-1:0] clk_out;
  logic [`LPF_N_OUT*`LPF_DIV_W-1:0] div_all;
  logic [`LPF_PH_W-1:0] ph_rel;

  // four-step ring, each step a quarter period
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_ph <= '0;
    end else if (i_clk_en) begin
      osc_ph <= pll_on ? osc_ph + `LPF_PH_W'(1) : '0;
    end
  end

  // selected phase: 0, 90, 180 or 270 degrees
  assign ph_rel = osc_ph - cfg.phase_sel;
  assign div_all = {div.div_c, div.div_b, div.div_a};

  genvar k;
  generate
    for (k = 0; k < `LPF_N_OUT; k++) begin : g_out
      assign osc_sel[k] = ~ph_rel[`LPF_PH_W-1];
      lpf_clk_div u_div (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_clk_en(i_clk_en),
        .i_run(pll_on),
        .i_osc(osc_sel[k]),
        .i_div(div_all[k*`LPF_DIV_W +: `LPF_DIV_W]),
        .o_clk(clk_out[k])
      );
    end
  endgenerate

  // divider flops drive the pins directly
  assign o_global_clock_out_a = clk_out[0];
  assign o_global_clock_out_b = clk_out[1];
  assign o_global_clock_out_c = clk_out[2];

endmodule // lpf_freeze_ctrl

// ### verification/lpf_freeze_ctrl_asserts.sv
// concurrent checks on the ports of the freeze controller
`timescale 1ns/10ps
module lpf_freeze_chk #(
  parameter int N_BANKS = 4,
  parameter int BANK_W = 8
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // watched ports
  input wire logic i_freeze_request_pin,
  input wire logic o_pll_powerdown,
  input wire logic o_global_clock_out_a,
  input wire logic o_global_clock_out_b,
  input wire logic o_global_clock_out_c,
  input wire logic o_glob_en,
  input wire logic o_clocks_ready,
  input wire logic [N_BANKS*BANK_W-1:0] o_core_in,
  input wire logic o_jtag_accept,
  input wire logic o_jtag_refuse
);
  // one clock domain for every property
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  wire any_clk = o_global_clock_out_a | o_global_clock_out_b |
    o_global_clock_out_c;
  // divider flop may need one edge to settle after the stop
  a_pll_stopped: assert property (
    o_pll_powerdown && $past(o_pll_powerdown) |-> !any_clk)
    else $error("clock output runs while frozen");
  a_glob_frozen: assert property (
    o_pll_powerdown |-> !o_glob_en && !o_clocks_ready)
    else $error("globals or ready live while frozen");
  a_core_high: assert property (
    o_pll_powerdown && $past(o_pll_powerdown) |-> &o_core_in)
    else $error("core input not high while frozen");
  a_jtag_accept: assert property (
    o_jtag_accept |-> !$past(o_pll_powerdown))
    else $error("jtag accepted while frozen");
  a_jtag_refuse: assert property (
    o_jtag_refuse |-> !$past(o_clocks_ready))
    else $error("jtag refused in normal run");
  a_jtag_excl: assert property (
    !(o_jtag_accept && o_jtag_refuse))
    else $error("jtag accepted and refused at once");
  a_exit_glob: assert property (
    $fell(o_pll_powerdown) |-> !o_glob_en ##[1:4] o_glob_en)
    else $error("global release out of step on exit");
  a_pin_exit: assert property (
    $fell(i_freeze_request_pin) |-> ##[1:4] !o_pll_powerdown)
    else $error("no exit after pin release");
  a_pin_entry: assert property (
    $rose(o_pll_powerdown) |-> $past(i_freeze_request_pin, 3))
    else $error("freeze entered without the pin");
  // main scenarios reached
  c_freeze: cover property ($rose(o_pll_powerdown));
  c_refuse: cover property (o_jtag_refuse);
  c_ready: cover property ($rose(o_clocks_ready));
endmodule // lpf_freeze_chk

bind lpf_freeze_ctrl lpf_freeze_chk #(
  .N_BANKS(N_BANKS), .BANK_W(BANK_W)) u_lpf_freeze_chk (
  .i_ref_clk, .i_rst_n, .i_freeze_request_pin, .o_pll_powerdown,
  .o_global_clock_out_a, .o_global_clock_out_b, .o_global_clock_out_c,
  .o_glob_en, .o_clocks_ready, .o_core_in, .o_jtag_accept,
  .o_jtag_refuse);

// ### verification/lpf_board.sv
// board controller model: freeze pin and pll lock source
`timescale 1ns/10ps
module lpf_board #(
  parameter int FAST = 4,
  parameter int SLOW = 40
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // commands from the bench
  input wire logic i_hold,
  input wire logic i_slow,
  // device side
  input wire logic i_pll_powerdown,
  output logic o_freeze_request_pin,
  output logic o_pll_lock
);
  int cnt;
  // pin stays up as long as the hold command stands
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_freeze_request_pin <= 1'b0;
      cnt <= 0;
    end else begin
      o_freeze_request_pin <= i_hold;
      cnt <= i_pll_powerdown ? 0 : cnt + 1;
    end
  end
  // lock drops at once on stop, returns after a fast or slow acquisition
  assign o_pll_lock = !i_pll_powerdown && cnt >= (i_slow ? SLOW : FAST);
endmodule // lpf_board

// ### verification/tb_lpf_freeze_ctrl.sv
// self-checking bench of the freeze controller
`timescale 1ns/10ps
`include "lpf_regs.svh"
module tb_lpf_freeze_ctrl;
  localparam int ACQ = 20;
  localparam int SLOW = 40;
  logic clk, rst_n, wr, rd, core_req, hold, slow, jreq, en;
  logic lock, pin, pd, ga, gb, gc, glob, ready, jacc, jref;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, pad_in, core_out, pad_out, oe_n, core_in;
  int errors, num_checks, cyc_n, i, a, b, base;
  wire [2:0] gclk = {gc, gb, ga};
  // device under test and board controller
  lpf_freeze_ctrl #(.ACQ_CYC(`LPF_ACQ_W'(ACQ))) u_lpf_freeze_ctrl (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(en), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_freeze_request_pin(pin), .i_core_freeze_request(core_req),
    .i_pll_lock(lock), .o_pll_powerdown(pd), .o_global_clock_out_a(ga),
    .o_global_clock_out_b(gb), .o_global_clock_out_c(gc),
    .o_glob_en(glob), .o_clocks_ready(ready), .i_pad_in(pad_in),
    .i_core_out(core_out), .o_pad_out(pad_out), .o_pad_oe_n(oe_n),
    .o_core_in(core_in), .i_jtag_req(jreq), .o_jtag_accept(jacc),
    .o_jtag_refuse(jref));
  lpf_board #(.SLOW(SLOW)) u_lpf_board (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_hold(hold), .i_slow(slow),
    .i_pll_powerdown(pd), .o_freeze_request_pin(pin), .o_pll_lock(lock));
  // ****
  // helpers
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic ok(input logic c);
    chk({31'h0, c}, 32'h1);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] ad, input logic [31:0] d);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] ad, input logic [31:0] m,
                        input logic [31:0] e);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata & m, e);
    @(posedge clk);
  endtask
  task automatic wait_pd(input logic v);
    for (i = 0; i < 10 && pd !== v; i++) begin
      @(posedge clk);
      #1;
    end
    ok(pd === v);
  endtask
  task automatic jtag(input logic acc);
    jreq <= 1'b1;
    for (i = 0; i < 8 && !(jacc || jref); i++) begin
      @(posedge clk);
      #1;
    end
    chk({30'h0, jacc, jref}, {30'h0, acc, !acc});
    @(posedge clk);
    jreq <= 1'b0;
    cyc(4);
  endtask
  // cycle number of the next rising edge of divided clock s
  task automatic rise(input int s, output int t);
    logic pv;
    pv = 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      #1;
      if (gclk[s] === 1'b1 && pv === 1'b0) break;
      pv = gclk[s];
    end
    t = cyc_n;
  endtask
  // release the pin and time globals, banks and ready
  task automatic leave(input int min_rdy);
    int t, tp, tg, k;
    int tb [4];
    tp = 0;
    tg = 0;
    tb = '{0, 0, 0, 0};
    hold <= 1'b0;
    for (t = 1; t < 300 && ready !== 1'b1; t++) begin
      @(posedge clk);
      #1;
      if (tp == 0 && pd === 1'b0) tp = t;
      if (tg == 0 && glob === 1'b1) tg = t;
      for (k = 0; k < 4; k++)
        if (tb[k] == 0 && core_in[8*k +: 8] === 8'h00) tb[k] = t;
    end
    ok(tp > 0 && tp < 8);
    ok(tg > tp && tg < tb[0]);
    for (k = 0; k < 3; k++) begin
      chk(32'(tb[k+1] - tb[k]), `LPF_BANK_STEP);
    end
    ok(tb[3] > 0 && tb[3] < t);
    ok(ready === 1'b1 && t - tp >= min_rdy);
  endtask
  task automatic final_report;
    if (errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ****
  // clock, timeout and sequence
  // ****
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      errors = errors + 1;
      final_report();
    end
  end
  initial begin
    rst_n = 1'b0;
    {wr, rd, core_req, hold, slow, jreq} = '0;
    en = 1'b1;
    {addr, wdata, pad_in, core_out} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_reg(`LPF_STAT_OFS, 32'hF8F, 32'hF81);
    rd_reg(8'h0C, '1, 32'h0);
    wr_reg(`LPF_DIV_OFS, 32'hFFFF0C41);
    rd_reg(`LPF_DIV_OFS, '1, 32'hC41);
    // output periods follow divide ratios 1, 2 and 3
    for (int s = 0; s < 3; s++) begin
      rise(s, a);
      rise(s, b);
      chk(32'(b - a), 32'(4 * (s + 1)));
    end
    // each 90 degree step moves the edge one cycle
    for (int p = 0; p < 4; p++) begin
      wr_reg(`LPF_CTRL_OFS, 32'(p << 1));
      cyc(8);
      rise(0, a);
      if (p == 0) base = a;
      chk(32'((a - base) % 4), 32'(p));
    end
    // pin-only freeze with bank 1 holding its output
    wr_reg(`LPF_CTRL_OFS, 32'h10);
    core_out <= 32'hA5A5A5A5;
    slow <= 1'b1;
    hold <= 1'b1;
    wait_pd(1'b1);
    core_out <= 32'h5A5A5A5A;
    cyc(3);
    #1;
    chk({29'h0, gclk}, 32'h0);
    chk(oe_n, 32'hFFFF00FF);
    chk(pad_out, 32'h0000A500);
    chk(core_in, 32'hFFFFFFFF);
    rd_reg(`LPF_STAT_OFS, 32'hF8F, 32'h2);
    jtag(1'b0);
    leave(SLOW);
    chk(pad_out, 32'h5A5A5A5A);
    jtag(1'b1);
    // enable low: pin is not even synchronised, state stands
    en <= 1'b0;
    hold <= 1'b1;
    cyc(10);
    #1;
    ok(pd === 1'b0 && ready === 1'b1); // clock enable freezes state
    hold <= 1'b0;
    cyc(3);
    en <= 1'b1;
    // qualified freeze: pin alone is not enough
    wr_reg(`LPF_CTRL_OFS, 32'h1);
    slow <= 1'b0;
    hold <= 1'b1;
    cyc(10);
    #1;
    ok(pd === 1'b0);
    core_req <= 1'b1;
    wait_pd(1'b1);
    core_req <= 1'b0;
    cyc(4);
    #1;
    ok(pd === 1'b1);
    chk(oe_n, 32'hFFFFFFFF);
    leave(ACQ);
    final_report();
  end
endmodule // tb_lpf_freeze_ctrl
